// *** hw/temp_sequence_and_stop_delay.sv ***
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "temp_stop_defs.svh"
module temp_sequence_and_stop_delay
  import temp_stop_pkg::*;
#(
  parameter int XTAL_DIV = `XTAL_DIV
) (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        temp_start_in,
  input  wire logic        launch_pulse_in,
  input  wire logic        upstream_stop_input_in,
  input  wire logic        downstream_stop_input_in,
  input  wire logic        early_edge_in,
  output logic             upstream_stop_out,
  output logic             downstream_stop_out,
  output logic             early_edge_out,
  output logic             blanking_out,
  output logic             preamble_out,
  output logic             port_strobe_out,
  output logic [1:0]       port_out,
  output logic             temp_busy_out
);
  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic [15:0] temp_cfg_q;
  logic [15:0] stop_dly_q;
  logic [15:0] dly_cnt_q;
  logic        blank_q;
  temp_state_t state_q;
  logic [2:0]  pre_cnt_q;
  logic [1:0]  idx_q;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      temp_cfg_q <= `TEMP_CFG_RESET;
      stop_dly_q <= `STOP_DLY_RESET;
    end else if (req && wb_we_in) begin
      if (wb_adr_in == `ADDR_TEMP_CFG) begin
        temp_cfg_q <= merge16(temp_cfg_q, wb_dat_in, wb_sel_in);
      end else if (wb_adr_in == `ADDR_STOP_DLY) begin
        stop_dly_q <= merge16(stop_dly_q, wb_dat_in, wb_sel_in);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      if (wb_adr_in == `ADDR_TEMP_CFG) begin
        wb_dat_out <= {16'h0000, temp_cfg_q};
      end else if (wb_adr_in == `ADDR_STOP_DLY) begin
        wb_dat_out <= {16'h0000, stop_dly_q};
      end else if (wb_adr_in == `ADDR_STATUS) begin
        wb_dat_out <= {dly_cnt_q, 8'h00, 2'b00, idx_q, pre_cnt_q, blank_q};
      end else begin
        wb_dat_out <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Crystal-rate tick, every XTAL_DIV clocks (12 at 50 MHz, 240 ns).
  // ****************************************************************
  logic [7:0] div_q;
  logic       tick_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || launch_pulse_in) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == 8'(XTAL_DIV - 1)) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Stop blanking.
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dly_cnt_q <= 16'h0000;
      blank_q   <= 1'b0;
    end else if (launch_pulse_in) begin
      dly_cnt_q <= stop_dly_q;
      blank_q   <= (stop_dly_q != 16'h0000);
    end else if (blank_q && tick_q) begin
      dly_cnt_q <= dly_cnt_q - 16'h0001;
      blank_q   <= (dly_cnt_q != 16'h0001);
    end
  end

  // Stops are also held off in the launch cycle when the stop delay is nonzero, before the blanking flag is up.
  wire logic gate_w = blank_q || (launch_pulse_in && (stop_dly_q != 16'h0000));

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      upstream_stop_out   <= 1'b0;
      downstream_stop_out <= 1'b0;
      early_edge_out      <= 1'b0;
      blanking_out        <= 1'b0;
    end else begin
      upstream_stop_out   <= upstream_stop_input_in && !gate_w;
      downstream_stop_out <= downstream_stop_input_in && !gate_w;
      early_edge_out      <= early_edge_in && !gate_w;
      blanking_out        <= blank_q;
    end
  end

  // ****************************************************************
  // Temperature sequencing.
  // ****************************************************************
  function automatic logic [1:0] port_count(input logic [1:0] sel_code);
    case (sel_code)
      2'b00:   port_count = 2'h1;
      2'b01:   port_count = 2'h1;
      2'b10:   port_count = 2'h2;
      default: port_count = 2'h3;
    endcase
  endfunction : port_count

  function automatic port_id_t port_at(input logic [1:0] sel_code, input logic [1:0] i);
    logic [1:0] t;
    case (i)
      2'h0:    t = (sel_code == 2'b01) ? 2'h1 : 2'h0;
      2'h1:    t = (sel_code == 2'b01) ? 2'h3 : 2'h2;
      2'h2:    t = 2'h1;
      default: t = 2'h3;
    endcase
    port_at = t;
  endfunction : port_at

  logic [11:0] wait_q;
  wire  logic [1:0]  temp_port_select = temp_cfg_q[`PORT_SEL_HI:`PORT_SEL_LO];
  wire  logic [11:0] ivl_w = 12'(({10'h000, temp_cfg_q[`PIV_HI:`PIV_LO]} + 12'h001) * `INTERVAL_UNIT_TICKS);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q         <= ST_IDLE;
      pre_cnt_q       <= 3'h0;
      idx_q           <= 2'h0;
      wait_q          <= 12'h000;
      port_strobe_out <= 1'b0;
      preamble_out    <= 1'b0;
      port_out        <= 2'h0;
      temp_busy_out   <= 1'b0;
    end else begin
      port_strobe_out <= 1'b0;
      preamble_out    <= 1'b0;
      if (wait_q != 12'h000 && tick_q) begin
        wait_q <= wait_q - 12'h001;
      end
      case (state_q)
        ST_IDLE: begin
          temp_busy_out <= 1'b0;
          if (temp_start_in) begin
            pre_cnt_q     <= temp_cfg_q[`PRE_HI:`PRE_LO];
            idx_q         <= 2'h0;
            wait_q        <= 12'h000;
            temp_busy_out <= 1'b1;
            state_q       <= (temp_cfg_q[`PRE_HI:`PRE_LO] != 3'h0) ? ST_PRE : ST_PORT;
          end
        end
        ST_PRE: begin
          if (wait_q == 12'h000) begin
            preamble_out <= 1'b1;
            port_out     <= port_at(temp_port_select, 2'h0);
            wait_q       <= ivl_w;
            pre_cnt_q    <= pre_cnt_q - 3'h1;
            if (pre_cnt_q == 3'h1) begin
              state_q <= ST_PORT;
            end
          end
        end
        ST_PORT: begin
          if (wait_q == 12'h000) begin
            port_strobe_out <= 1'b1;
            port_out        <= port_at(temp_port_select, idx_q);
            wait_q          <= ivl_w;
            idx_q           <= idx_q + 2'h1;
            if (idx_q == port_count(temp_port_select)) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Interval watch.
  // ****************************************************************
  logic [15:0] gap_q;
  logic [11:0] ivl_q;
  logic        seen_q;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || state_q == ST_IDLE) begin
      gap_q  <= 16'h0000;
      ivl_q  <= 12'h000;
      seen_q <= 1'b0;
    end else if (preamble_out || port_strobe_out) begin
      gap_q  <= 16'h0001;
      ivl_q  <= wait_q;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  blank_stop_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    blank_q |=> !upstream_stop_out && !downstream_stop_out) else $error("stop passed while blanked");
  blank_early_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    blank_q |=> !early_edge_out) else $error("early edge passed while blanked");
  launch_load_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    launch_pulse_in |=> dly_cnt_q == $past(stop_dly_q)) else $error("delay not loaded at launch");
  dly_step_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (blank_q && !launch_pulse_in && tick_q) |=> dly_cnt_q == $past(dly_cnt_q) - 16'h0001)
    else $error("delay count step wrong");
  dly_hold_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (!launch_pulse_in && !tick_q) |=> $stable(dly_cnt_q)) else $error("delay count moved off tick");
  open_stop_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (!blank_q && !launch_pulse_in && upstream_stop_input_in) |=> upstream_stop_out) else $error("stop lost when open");
  launch_gate_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (launch_pulse_in && stop_dly_q != 16'h0000) |=> !upstream_stop_out && !downstream_stop_out && !early_edge_out)
    else $error("stop passed at launch");
  launch_blank_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (launch_pulse_in && stop_dly_q != 16'h0000) |=> blank_q) else $error("launch did not start blanking");
  open_down_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (!blank_q && !launch_pulse_in && downstream_stop_input_in) |=> downstream_stop_out)
    else $error("downstream stop lost when open");
  open_early_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (!blank_q && !launch_pulse_in && early_edge_in) |=> early_edge_out)
    else $error("early edge lost when open");
  pre_run_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    preamble_out |-> state_q != ST_IDLE) else $error("preamble after sequence end");
  blank_out_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    blank_q |=> blanking_out) else $error("blanking flag not shown");
  gap_low_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    ((preamble_out || port_strobe_out) && seen_q) |-> int'(gap_q) >= (int'(ivl_q) - 1) * XTAL_DIV + 2)
    else $error("measurement interval too short");
  pre_count_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (state_q == ST_IDLE && temp_start_in && temp_cfg_q[`PRE_HI:`PRE_LO] == 3'h0) |=> state_q == ST_PORT)
    else $error("preamble not skipped");
  port_first_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_strobe_out && $past(idx_q) == 2'h0 && temp_port_select == 2'b01) |-> port_out == 2'h1)
    else $error("wrong first port");
  ivl_load_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    port_strobe_out |-> wait_q == ivl_w) else $error("interval not loaded");
  blank_cov_c: cover property (@(posedge ref_clk_in) launch_pulse_in ##1 blank_q ##[1:1000] !blank_q);
  seq_cov_c: cover property (@(posedge ref_clk_in) state_q == ST_PORT ##1 state_q == ST_IDLE);
  pre_cov_c: cover property (@(posedge ref_clk_in) preamble_out);
  launch_stop_c: cover property (@(posedge ref_clk_in) launch_pulse_in && upstream_stop_input_in);
  last_port_c: cover property (@(posedge ref_clk_in) port_strobe_out && port_out == 2'h3);
endmodule : temp_sequence_and_stop_delay
`default_nettype wire

// *** pkg/temp_stop_defs.svh ***
`ifndef TEMP_STOP_DEFS_SVH
`define TEMP_STOP_DEFS_SVH
// ****************************************************************
// Register map and field layout.
// ****************************************************************
`define ADDR_TEMP_CFG       4'h0
`define ADDR_STOP_DLY       4'h4
`define ADDR_STATUS         4'h8
`define PORT_SEL_HI         6
`define PORT_SEL_LO         5
`define PRE_HI              4
`define PRE_LO              2
`define PIV_HI              1
`define PIV_LO              0
`define TEMP_CFG_RESET      16'h0000
`define STOP_DLY_RESET      16'h0000
// ****************************************************************
// Timing.
// ****************************************************************
`define CLK_MHZ             50
`define XTAL_MHZ            4
`define XTAL_DIV            (`CLK_MHZ / `XTAL_MHZ)
`define INTERVAL_UNIT_US    128
`define INTERVAL_UNIT_TICKS (`INTERVAL_UNIT_US * `XTAL_MHZ)
`endif

// *** pkg/temp_stop_pkg.sv ***
package temp_stop_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_PORT = 2'b10
  } temp_state_t;
  typedef logic [1:0] port_id_t;
endpackage : temp_stop_pkg

// *** dv/echo_comparator_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Receiver comparators seen by the block.
// ****************************************
module echo_comparator_model (
  input  wire logic ref_clk_in,
  input  wire logic arm_in,
  output wire logic up_level_out,
  output wire logic dn_level_out,
  output wire logic early_level_out
);
  // Each comparator sits high while an echo is present.
  assign up_level_out    = arm_in;
  assign dn_level_out    = arm_in;
  assign early_level_out = arm_in;
endmodule : echo_comparator_model
`default_nettype wire

// *** dv/temp_sequence_and_stop_delay_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module temp_sequence_and_stop_delay_tb_top
  import temp_stop_pkg::*;
;
  localparam int XD = 1;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, start = 0, launch = 0, arm = 0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, dat_o;
  logic ack, up_o, dn_o, ee_o, blank, pre, pstb, busy;
  logic [1:0] port;
  wire logic up_c, dn_c, ee_c;
  int err_count = 0, comparisons = 0, cyc_n = 0, pre_n = 0;
  int ev_t[$];
  logic [1:0] ports[$];
  always #10 clk = ~clk;
  temp_sequence_and_stop_delay #(.XTAL_DIV(XD)) DUT (.ref_clk_in(clk), .srst_in(srst),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack), .temp_start_in(start),
    .launch_pulse_in(launch), .upstream_stop_input_in(up_c), .downstream_stop_input_in(dn_c),
    .early_edge_in(ee_c), .upstream_stop_out(up_o), .downstream_stop_out(dn_o),
    .early_edge_out(ee_o), .blanking_out(blank), .preamble_out(pre),
    .port_strobe_out(pstb), .port_out(port), .temp_busy_out(busy));
  echo_comparator_model echo (.ref_clk_in(clk), .arm_in(arm), .up_level_out(up_c),
    .dn_level_out(dn_c), .early_level_out(ee_c));
  // ****************************************
  // Event log of the temperature sequence.
  // ****************************************
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (pre === 1'b1) begin
      pre_n++;
      ev_t.push_back(cyc_n);
    end
    if (pstb === 1'b1) begin
      ports.push_back(port);
      ev_t.push_back(cyc_n);
    end
  end
  task final_report();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task chk_near(input int got, input int exp);
    comparisons++;
    if (got < exp - 2 || got > exp + 2) begin
      err_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_near
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      final_report();
    end
    r = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task regs_check();
    logic [31:0] r;
    wb(0, 4'h0, 0, r); chk32(r, 32'h0);
    wb(0, 4'h4, 0, r); chk32(r, 32'h0);
    wb(1, 4'h0, 32'hFFFF_FFFF, r);
    wb(0, 4'h0, 0, r); chk32(r, 32'h0000_FFFF);
    wb(1, 4'h4, 32'h0000_FFFF, r);
    wb(0, 4'h4, 0, r); chk32(r, 32'h0000_FFFF);
    wb(1, 4'h4, 32'h0, r);
    wb(0, 4'h4, 0, r); chk32(r, 32'h0);
    sel <= 4'h2;
    wb(1, 4'h4, 32'hFFFF_5A3C, r);
    sel <= 4'hF;
    wb(0, 4'h4, 0, r); chk32(r, 32'h0000_5A00);
    wb(1, 4'h8, 32'hFFFF_FFFF, r);
    wb(0, 4'h8, 0, r); chk32(r, 32'h0);
    wb(0, 4'hC, 0, r); chk32(r, 32'h0);
  endtask : regs_check
  task seq_check(input logic [1:0] psel, input logic [2:0] pc, input logic [1:0] pi);
    logic [31:0] r;
    logic [1:0] exp[$];
    int n;
    case (psel)
      2'd0: exp = '{2'd0, 2'd2};
      2'd1: exp = '{2'd1, 2'd3};
      2'd2: exp = '{2'd0, 2'd2, 2'd1};
      default: exp = '{2'd0, 2'd2, 2'd1, 2'd3};
    endcase
    wb(1, 4'h0, {25'h0, psel, pc, pi}, r);
    pre_n = 0;
    ports.delete();
    ev_t.delete();
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 40000; n++) begin
      @(posedge clk);
      if (n > 2 && busy === 1'b0) break;
    end
    if (n == 40000) begin
      err_count++;
      final_report();
    end
    chk32(pre_n, {29'h0, pc});
    chk32(ports.size(), exp.size());
    foreach (exp[i]) if (i < ports.size()) chk32({30'h0, ports[i]}, {30'h0, exp[i]});
    for (n = 1; n < ev_t.size(); n++) chk_near(ev_t[n] - ev_t[n-1], (pi + 1) * 512 * XD);
  endtask : seq_check
  task blank_check(input logic [15:0] d);
    logic [31:0] r;
    int n, cnt;
    wb(1, 4'h4, {16'h0, d}, r);
    arm <= 1'b1;
    launch <= 1'b1;
    @(posedge clk);
    launch <= 1'b0;
    cnt = 0;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (blank === 1'b1) begin
        cnt++;
        chk32({up_o, dn_o, ee_o}, 32'h0);
      end else if (n > 2) break;
    end
    if (n == 2000) begin
      err_count++;
      final_report();
    end
    chk_near(cnt, d * XD);
    repeat (2) @(posedge clk);
    chk32({up_o, dn_o, ee_o}, 32'h7);
    arm <= 1'b0;
    @(posedge clk);
  endtask : blank_check
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    regs_check();
    seq_check(2'd0, 3'd0, 2'd0);
    seq_check(2'd1, 3'd7, 2'd1);
    seq_check(2'd2, 3'd3, 2'd2);
    seq_check(2'd3, 3'd5, 2'd3);
    blank_check(16'h0012);
    blank_check(16'h0040);
    final_report();
  end
endmodule : temp_sequence_and_stop_delay_tb_top
`default_nettype wire
